// File: hw/wfg_deadtime.sv
// dead-time insertion for one complementary output pair
`include "wfg_params.svh"
`default_nettype none

module wfg_deadtime (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic raw,
    input wire logic [`WFG_DT_W-1:0] dead_time,
    output wfg_pkg::wfg_pair_t pair
);
    import wfg_pkg::*;

    logic last_ff;
    logic [`WFG_DT_W-1:0] gap_ff;
    logic settled;

    // a side turns on only once raw has been stable past the gap
    assign settled = (raw == last_ff) && (gap_ff == '0);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ff <= 1'b0;
            gap_ff <= '0;
        end else begin
            last_ff <= raw;
            if (raw != last_ff) begin
                gap_ff <= dead_time;
            end else if (gap_ff != '0) begin
                gap_ff <= gap_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pair <= '0;
        end else begin
            pair.hi <= raw & settled;
            pair.lo <= ~raw & settled;
        end
    end

endmodule : wfg_deadtime

`default_nettype wire

// File: hw/wfg_sync.sv
// two-flop synchroniser for one level from outside the clock domain
`default_nettype none

module wfg_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule : wfg_sync

`default_nettype wire

// File: hw/wfg_waveform_generator.sv
// three-phase waveform generator: timebase, buffers, channels, pins
`include "wfg_params.svh"
`default_nettype none

module wfg_waveform_generator #(
    parameter int NUM_CH = `WFG_NUM_CH,
    parameter int STATE_CYC = `WFG_STATE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ctrl_wr,
    input wire wfg_pkg::wfg_ctrl_t ctrl_wdata,
    input wire logic reload_wr,
    input wire logic [`WFG_CNT_W-1:0] reload_wdata,
    input wire logic [NUM_CH-1:0] compare_wr,
    input wire logic [`WFG_CNT_W-1:0] compare_wdata,
    input wire logic outctl_wr,
    input wire wfg_pkg::wfg_outctl_t outctl_wdata,
    input wire logic capture_compare_channel_zero,
    input wire logic capture_compare_channel_two,
    input wire logic peripheral_function_enable_zero,
    input wire logic peripheral_function_enable_two,
    input wire logic external_fault_input,
    input wire logic fault_detect_en,
    input wire logic sw_disable,
    input wire logic disable_clear,
    output wire logic [2*NUM_CH-1:0] pwm_pin,
    output logic [`WFG_CNT_W-1:0] timebase_count,
    output logic count_dir,
    output wfg_pkg::wfg_ctrl_t ctrl_q,
    output logic [`WFG_CNT_W-1:0] reload_buf_q,
    output wire logic [NUM_CH-1:0][`WFG_CNT_W-1:0] compare_buf_q,
    output wfg_pkg::wfg_outctl_t outctl_buf_q,
    output logic fault_irq,
    output logic outputs_disabled
);
    import wfg_pkg::*;

    localparam int CW = `WFG_CNT_W;
    localparam logic [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

    generate
        if (NUM_CH != `WFG_NUM_CH) begin : g_bad_ch
            $error("channel count must match the pin layout");
        end
        if (STATE_CYC < 1 || STATE_CYC > 16) begin : g_bad_state
            $error("state time must be 1 to 16 cycles");
        end
    endgenerate

    // active registers hidden behind the buffers, plus phase, hold and fault delay state
    logic [CW-1:0] reload_act_ff;
    wfg_outctl_t oc_act_ff;
    wfg_phase_t phase_ff;
    logic [3:0] hold_ff;
    logic fault_d_ff;

    wfg_mode_t mode;
    logic center;
    logic stopped;
    logic pfe_event;
    logic early;
    logic at_peak;
    logic at_valley;
    logic upd_pt;
    logic fault_s;
    logic fault_valid;

    assign mode = ctrl_q.mode;
    // high mode bit picks edge-aligned counting
    assign center = ~mode[1];

    // counter idles when disabled or holding zero
    assign stopped = ~ctrl_q.count_enable
        | (timebase_count == '0);

    assign pfe_event =
        (capture_compare_channel_zero & peripheral_function_enable_zero)
        | (capture_compare_channel_two
        & peripheral_function_enable_two);

    assign early = ~stopped & (mode == WFG_MODE_EDGE3)
        & pfe_event;

    assign at_peak = ~stopped & (timebase_count == reload_act_ff)
        & (~center | (phase_ff == WFG_PH_UP)
        | ((phase_ff == WFG_PH_HOLD) && (hold_ff == '0)));

    assign at_valley = ~stopped & center & (phase_ff == WFG_PH_DOWN)
        & (timebase_count == ONE);

    // update points for compare and output control
    assign upd_pt = at_peak | early
        | ((mode == WFG_MODE_CTR1) & at_valley);

    // software-visible buffers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_buf_q <= `WFG_RELOAD_RST;
        end else if (reload_wr) begin
            reload_buf_q <= reload_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            outctl_buf_q <= '0;
        end else if (outctl_wr) begin
            outctl_buf_q <= outctl_wdata;
        end
    end

    // output control: sync bit read live from the buffer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_act_ff <= '0;
        end else if (!outctl_buf_q.sync) begin
            oc_act_ff <= outctl_buf_q;
        end else if (upd_pt) begin
            oc_act_ff <= outctl_buf_q;
        end
    end

    // timebase counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timebase_count <= `WFG_COUNT_RST;
            reload_act_ff <= `WFG_RELOAD_RST;
            phase_ff <= WFG_PH_DOWN;
            hold_ff <= '0;
            count_dir <= 1'b0;
        end else if (stopped) begin
            if (reload_wr) begin
                reload_act_ff <= reload_wdata;
                hold_ff <= '0;
                if (center) begin
                    timebase_count <= reload_wdata;
                    phase_ff <= WFG_PH_DOWN;
                    count_dir <= 1'b0;
                end else begin
                    timebase_count <= ONE;
                    phase_ff <= WFG_PH_UP;
                    count_dir <= 1'b1;
                end
            end
        end else if (!center) begin
            count_dir <= 1'b1;
            phase_ff <= WFG_PH_UP;
            if (at_peak || early) begin
                timebase_count <= ONE;
                reload_act_ff <= reload_buf_q;
            end else begin
                timebase_count <= timebase_count + ONE;
            end
        end else if (at_peak) begin
            timebase_count <= reload_buf_q;
            reload_act_ff <= reload_buf_q;
            phase_ff <= WFG_PH_DOWN;
            count_dir <= 1'b0;
        end else begin
            case (phase_ff)
                WFG_PH_DOWN: begin
                    if (at_valley) begin
                        phase_ff <= WFG_PH_HOLD;
                        hold_ff <= 4'(STATE_CYC - 1);
                    end else begin
                        timebase_count <= timebase_count - ONE;
                    end
                end
                WFG_PH_HOLD: begin
                    if (hold_ff == '0) begin
                        phase_ff <= WFG_PH_UP;
                        count_dir <= 1'b1;
                        timebase_count <= timebase_count + ONE;
                    end else begin
                        hold_ff <= hold_ff - 4'h1;
                    end
                end
                WFG_PH_UP: begin
                    timebase_count <= timebase_count + ONE;
                end
                default: begin
                    phase_ff <= WFG_PH_DOWN;
                end
            endcase
        end
    end

    // fault protection
    wfg_sync u_fault_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(external_fault_input),
        .sync_out(fault_s)
    );

    assign fault_valid = fault_detect_en & fault_s & ~fault_d_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_d_ff <= 1'b0;
            fault_irq <= 1'b0;
        end else begin
            fault_d_ff <= fault_s;
            fault_irq <= fault_valid;
        end
    end

    // set beats clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            outputs_disabled <= 1'b0;
        end else if (fault_valid || sw_disable) begin
            outputs_disabled <= 1'b1;
        end else if (disable_clear) begin
            outputs_disabled <= 1'b0;
        end
    end

    // phase channels
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            logic [CW-1:0] cmp_buf_ff;
            logic [CW-1:0] cmp_act_ff;
            logic [1:0] pin_ff;
            logic raw;
            logic down;
            wfg_pair_t pair;
            logic [1:0] asserted;
            logic [1:0] sel;

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_buf_ff <= `WFG_COMPARE_RST;
                end else if (compare_wr[i]) begin
                    cmp_buf_ff <= compare_wdata;
                end
            end

            // stopped: follows the buffer one cycle after a write
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_act_ff <= `WFG_COMPARE_RST;
                end else if (stopped || upd_pt) begin
                    cmp_act_ff <= cmp_buf_ff;
                end
            end

            assign compare_buf_q[i] = cmp_buf_ff;

            assign down = center & (phase_ff != WFG_PH_UP);

            // drops at compare going up, returns at compare going down
            assign raw = ~stopped & (down
                ? (timebase_count <= cmp_act_ff)
                : (timebase_count < cmp_act_ff));

            wfg_deadtime u_dt (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .raw(raw),
                .dead_time(ctrl_q.dead_time),
                .pair(pair)
            );

            assign asserted = {pair.lo, pair.hi}
                & {2{~outputs_disabled}};
            assign sel = oc_act_ff.pwm_sel[2*i+1:2*i];

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_ff <= '0;
                end else begin
                    pin_ff <= (sel
                        & (asserted ^ {2{oc_act_ff.active_low}}))
                        | (~sel
                        & oc_act_ff.gpio_level[2*i+1:2*i]);
                end
            end

            assign pwm_pin[2*i+1:2*i] = pin_ff;
        end
    endgenerate

endmodule : wfg_waveform_generator

`default_nettype wire

// File: include/wfg_params.svh
// widths, reset values, field positions and timing counts of the generator
//
// Functional notes
// - three synchronized channels share carrier, dead-time and mode
// - modes 0,1 count up/down centered; modes 2,3 count up edge-aligned
// - dead-time keeps a channel's two outputs from asserting together
// - each pin is general output or pwm; asserted level selectable
// - external or software disable forces pwm-selected outputs to deasserted level
// - valid fault input event raises interrupt and disables outputs
// - active-high asserted drives 1; active-low asserted drives 0
// - counter stopped: compares load half a state time after write
// - buffers transfer at reload match; mode 1 compare/output control also at 1; mode 3 event
// - mode 3 reload follows capture/compare channel 0 or 2 events
// - sync bit is unbuffered; 1 syncs pin updates, 0 updates at once
// - reads of reload, compare, output control return buffers
// - 16-bit timebase counter clocked each oscillator period, readable
// - control holds two mode bits, count enable; reports direction
// - count of zero stops counter; running count stays 1..reload
// - centered: stopped reload write copies straight into count
// - centered: down to 1, hold a state time, up, reload at peak
// - edge-aligned: stopped reload write loads count with one
// - edge-aligned: up to reload, restart at 1 taking new reload
// - mode 3 capture/compare event restarts counter at 1 early
// - control bits 0 to 9 hold the ten-bit dead-time value
// - direction bit reads 1 counting up, 0 counting down
// - centered: assert from up start, drop at compare, back on down
// - edge: drop at compare match, reassert at restart to 1
`ifndef WFG_PARAMS_SVH
`define WFG_PARAMS_SVH

`define WFG_CNT_W 16
`define WFG_NUM_CH 3
`define WFG_DT_W 10
`define WFG_PINS 6

`define WFG_CTRL_DT_LSB 0
`define WFG_CTRL_EC_BIT 10
`define WFG_CTRL_MODE_LSB 11

`define WFG_COUNT_RST 16'h0000
`define WFG_RELOAD_RST 16'h0000
`define WFG_COMPARE_RST 16'h0000

`define WFG_CLK_PERIOD_PS 5000
`define WFG_STATE_TIME_PS 10000
`define WFG_STATE_CYC \
    ((`WFG_STATE_TIME_PS + `WFG_CLK_PERIOD_PS - 1) / `WFG_CLK_PERIOD_PS)

`endif

// File: include/wfg_pkg.sv
// types shared by the waveform generator modules
`include "wfg_params.svh"
`default_nettype none

package wfg_pkg;

    typedef enum logic [1:0] {
        WFG_MODE_CTR0 = 2'b00,
        WFG_MODE_CTR1 = 2'b01,
        WFG_MODE_EDGE2 = 2'b10,
        WFG_MODE_EDGE3 = 2'b11
    } wfg_mode_t;

    typedef enum logic [1:0] {
        WFG_PH_DOWN = 2'b00,
        WFG_PH_HOLD = 2'b01,
        WFG_PH_UP = 2'b10
    } wfg_phase_t;

    // bits 12:11 mode, bit 10 count enable, bits 9:0 dead-time
    typedef struct packed {
        wfg_mode_t mode;
        logic count_enable;
        logic [`WFG_DT_W-1:0] dead_time;
    } wfg_ctrl_t;

    typedef struct packed {
        logic sync;
        logic active_low;
        logic [`WFG_PINS-1:0] pwm_sel;
        logic [`WFG_PINS-1:0] gpio_level;
    } wfg_outctl_t;

    typedef struct packed {
        logic hi;
        logic lo;
    } wfg_pair_t;

endpackage : wfg_pkg

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the waveform generator
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import wfg_pkg::*;
    logic core_clk, rst_n, ctrl_wr, reload_wr, outctl_wr, watch, shoot;
    logic ev0, ev2, pfe0, pfe2, flt, flt_en, sw_dis, dis_clr, dir, irq, dis;
    logic [2:0] compare_wr;
    logic [15:0] reload_wdata, compare_wdata, cnt, rbuf;
    logic [2:0][15:0] cbuf;
    logic [5:0] pins;
    wfg_ctrl_t ctrl_wdata, ctrl_q;
    wfg_outctl_t outctl_wdata, obuf;
    int failures, n_tests;
    wfg_waveform_generator dut (.core_clk(core_clk), .rst_n(rst_n),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .reload_wr(reload_wr),
        .reload_wdata(reload_wdata), .compare_wr(compare_wr),
        .compare_wdata(compare_wdata), .outctl_wr(outctl_wr),
        .outctl_wdata(outctl_wdata), .capture_compare_channel_zero(ev0),
        .capture_compare_channel_two(ev2),
        .peripheral_function_enable_zero(pfe0),
        .peripheral_function_enable_two(pfe2), .external_fault_input(flt),
        .fault_detect_en(flt_en), .sw_disable(sw_dis),
        .disable_clear(dis_clr), .pwm_pin(pins), .timebase_count(cnt),
        .count_dir(dir), .ctrl_q(ctrl_q), .reload_buf_q(rbuf),
        .compare_buf_q(cbuf), .outctl_buf_q(obuf), .fault_irq(irq),
        .outputs_disabled(dis));
    wfg_gate_model gates (.core_clk(core_clk), .watch(watch),
        .active_low(obuf.active_low), .pwm_pin(pins), .shoot_ff(shoot));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tk
    task automatic wr(input int k, input logic [15:0] d);
        @(posedge core_clk);
        ctrl_wdata <= wfg_ctrl_t'(d[12:0]);
        reload_wdata <= d;
        compare_wdata <= d;
        outctl_wdata <= wfg_outctl_t'(d[13:0]);
        ctrl_wr <= (k == 0);
        reload_wr <= (k == 1);
        outctl_wr <= (k == 2);
        compare_wr <= (k >= 3) ? 3'(1 << (k - 3)) : 3'h0;
        @(posedge core_clk);
        {ctrl_wr, reload_wr, outctl_wr, compare_wr} <= '0;
        #1;
    endtask : wr
    task automatic clr;
        @(posedge core_clk);
        dis_clr <= 1'b1;
        @(posedge core_clk);
        dis_clr <= 1'b0;
        #1;
    endtask : clr
    task automatic t_count(input logic [1:0] m, input logic [15:0] r);
        logic [15:0] t, s0, s1, s2;
        wr(0, {3'h0, m, 1'b0, 10'h002});
        wr(1, r);
        chk(cnt, m[1] ? 16'h0001 : r);
        chk(rbuf, r);
        wr(3, r >> 1);
        wr(4, 16'h0000);
        wr(5, r);
        chk(cbuf[0], r >> 1);
        chk(16'(ctrl_q), {3'h0, m, 1'b0, 10'h002});
        wr(0, {3'h0, m, 1'b1, 10'h002});
        t = 16'h0;
        do begin tk(1); t++; end
        while (!(cnt === 16'h0002 && dir === m[1]) && t < 16'd300);
        {t, s0, s1, s2} = '0;
        watch = 1'b1;
        do begin
            tk(1);
            t++;
            s0 = s0 + 16'(pins[0]) + 16'(pins[1]);
            s1 = s1 + 16'(pins[3]);
            s2 = s2 + 16'(pins[2]) + 16'(pins[5]);
        end while (!(cnt === 16'h0002 && dir === m[1]) && t < 16'd300);
        watch = 1'b0;
        chk(t, m[1] ? r : 16'(2 * r + 1));
        chk(s0, t - 16'd6);
        chk(s1, t);
        chk(s2, 16'h0);
        tk(6);
    endtask : t_count
    task automatic ev(input logic z, input logic p0, input logic p2,
                      input logic [15:0] e);
        int i;
        i = 0;
        while (cnt !== 16'h0005 && i < 100) begin tk(1); i++; end
        @(posedge core_clk);
        ev0 <= z;
        ev2 <= ~z;
        pfe0 <= p0;
        pfe2 <= p2;
        @(posedge core_clk);
        {ev0, ev2, pfe0, pfe2} <= '0;
        #1;
        chk(cnt, e);
    endtask : ev
    task automatic t_event(input logic [1:0] m);
        wr(0, {3'h0, m, 1'b0, 10'h002});
        wr(1, 16'd40);
        wr(0, {3'h0, m, 1'b1, 10'h002});
        ev(1'b1, 1'b1, 1'b0, m[0] ? 16'h0001 : 16'h0007);
        ev(1'b0, 1'b0, 1'b1, m[0] ? 16'h0001 : 16'h0007);
        ev(1'b1, 1'b0, 1'b0, 16'h0007);
    endtask : t_event
    task automatic t_sync;
        int i;
        wr(2, {2'h0, 1'b0, 1'b0, 6'h00, 6'h15});
        i = 0;
        while (cnt !== 16'h0005 && i < 100) begin tk(1); i++; end
        wr(2, {2'h0, 1'b1, 1'b0, 6'h00, 6'h2a});
        tk(2);
        chk(16'(pins), 16'h0015);
        i = 0;
        while (cnt !== 16'h0002 && i < 100) begin tk(1); i++; end
        tk(1);
        chk(16'(pins), 16'h002a);
    endtask : t_sync
    task automatic t_dis;
        wr(2, {2'h0, 1'b0, 1'b1, 6'h3f, 6'h00});
        @(posedge core_clk);
        sw_dis <= 1'b1;
        @(posedge core_clk);
        sw_dis <= 1'b0;
        tk(3);
        chk(16'(pins), 16'h003f);
        chk(16'(dis), 16'h0001);
        wr(2, {2'h0, 1'b0, 1'b0, 6'h3f, 6'h00});
        tk(2);
        chk(16'(pins), 16'h0000);
        clr();
        chk(16'(dis), 16'h0000);
    endtask : t_dis
    task automatic t_fault;
        int i;
        @(posedge core_clk);
        flt <= 1'b1;
        tk(8);
        chk(16'(dis), 16'h0000);
        @(posedge core_clk);
        flt <= 1'b0;
        flt_en <= 1'b1;
        tk(4);
        @(posedge core_clk);
        flt <= 1'b1;
        i = 0;
        do begin tk(1); i++; end while (irq !== 1'b1 && i < 10);
        chk(16'(irq), 16'h0001);
        tk(2);
        chk(16'(dis), 16'h0001);
        chk(16'(pins), 16'h0000);
        @(posedge core_clk);
        flt <= 1'b0;
        clr();
        chk(16'(dis), 16'h0000);
    endtask : t_fault
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #50us;
        failures++;
        tally_and_finish();
    end
    initial begin
        {ctrl_wr, reload_wr, outctl_wr, compare_wr, ev0, ev2, pfe0, pfe2, flt,
            flt_en, sw_dis, dis_clr, reload_wdata, compare_wdata, ctrl_wdata,
            outctl_wdata} = '0;
        {watch, rst_n, failures, n_tests} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        tk(1);
        chk(cnt, 16'h0000);
        chk(rbuf, 16'h0000);
        wr(2, {2'h0, 1'b0, 1'b0, 6'h00, 6'h2a});
        tk(3);
        chk(16'(pins), 16'h002a);
        chk(16'(obuf), {2'h0, 1'b0, 1'b0, 6'h00, 6'h2a});
        wr(2, {2'h0, 1'b0, 1'b0, 6'h3f, 6'h00});
        for (int m = 0; m < 4; m++)
            t_count(2'(m), m > 1 ? 16'd12 : 16'd8);
        t_event(2'h3);
        t_event(2'h2);
        t_sync();
        t_dis();
        t_fault();
        chk(16'(shoot), 16'h0000);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// File: sim/wfg_gate_model.sv
// inverter gate drivers: flags both switches of a leg on together
`default_nettype none
module wfg_gate_model (
    input wire logic core_clk,
    input wire logic watch,
    input wire logic active_low,
    input wire logic [5:0] pwm_pin,
    output logic shoot_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] on;
    assign on = active_low ? ~pwm_pin : pwm_pin;
    initial shoot_ff = 1'b0;
    always @(posedge core_clk) begin
        if (watch && |(on[4:0] & on[5:1] & 5'h15)) shoot_ff <= 1'b1;
    end
endmodule : wfg_gate_model
`default_nettype wire

// File: sim/wfg_monitor.sv
// port checker for the waveform generator, bound to its top module
`default_nettype none
module wfg_monitor #(
    parameter int STATE_CYC = 2
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ctrl_wr,
    input wire logic reload_wr,
    input wire logic [15:0] reload_wdata,
    input wire logic capture_compare_channel_zero,
    input wire logic peripheral_function_enable_zero,
    input wire logic [15:0] timebase_count,
    input wire logic count_dir,
    input wire wfg_pkg::wfg_ctrl_t ctrl_q,
    input wire logic fault_irq,
    input wire logic outputs_disabled
);
    import wfg_pkg::*;
    logic ok;
    logic edg;
    assign ok = ctrl_q.count_enable && timebase_count != 16'h0000
        && !reload_wr && !ctrl_wr;
    assign edg = ctrl_q.mode[1];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    chk_stop_holds: assert property (
        !ctrl_q.count_enable && !reload_wr && !ctrl_wr
        |=> $stable(timebase_count)) else $error("count moved while stopped");
    chk_zero_stops: assert property (
        timebase_count == 16'h0000 && !reload_wr
        |=> timebase_count == 16'h0000) else $error("zero count ran");
    chk_center_load: assert property (
        reload_wr && !ctrl_wr && !ctrl_q.count_enable && !edg
        |=> timebase_count == $past(reload_wdata)) else $error("no copy");
    chk_edge_load: assert property (
        reload_wr && !ctrl_wr && !ctrl_q.count_enable && edg
        |=> timebase_count == 16'h0001) else $error("edge load not one");
    chk_down_step: assert property (
        ok && !edg && !count_dir && timebase_count > 16'h0001
        |=> timebase_count == $past(timebase_count) - 16'h0001)
        else $error("bad down step");
    chk_valley_hold: assert property (
        ok && !edg && timebase_count == 16'h0001
        && $past(timebase_count) == 16'h0002
        |-> (timebase_count == 16'h0001)[*3] ##1 timebase_count == 16'h0002)
        else $error("bad valley hold");
    chk_edge_step: assert property (
        ok && edg |=> timebase_count == $past(timebase_count) + 16'h0001
        || timebase_count == 16'h0001) else $error("bad edge step");
    chk_event_restart: assert property (
        ok && ctrl_q.mode == WFG_MODE_EDGE3 && capture_compare_channel_zero
        && peripheral_function_enable_zero |=> timebase_count == 16'h0001)
        else $error("no early restart");
    chk_edge_dir: assert property (
        (ok && edg)[*2] |-> count_dir) else $error("edge dir not up");
    chk_irq_disable: assert property (
        fault_irq |-> ##[0:1] outputs_disabled) else $error("irq no disable");
    chk_irq_pulse: assert property (
        fault_irq |=> !fault_irq) else $error("irq not a pulse");
endmodule : wfg_monitor
bind wfg_waveform_generator wfg_monitor #(.STATE_CYC(STATE_CYC)) u_mon (
    .core_clk, .rst_n, .ctrl_wr, .reload_wr, .reload_wdata,
    .capture_compare_channel_zero, .peripheral_function_enable_zero,
    .timebase_count, .count_dir, .ctrl_q, .fault_irq, .outputs_disabled);
`default_nettype wire
